// >>> logic/sdc_pkg.sv
// Purpose: shared constants for the serial time-slot data controller
// Assumes: byte-wide software window, two 32-byte pools per direction
// Notes: status vector bit positions are fixed here for all users
package sdc_pkg;
    localparam logic [7:0] HOST_WIN_LO = 8'h80;
    localparam logic [7:0] HOST_WIN_HI = 8'hbf;
    localparam logic [15:0] DSP_WIN_LO = 16'h3080;
    localparam logic [15:0] DSP_WIN_HI = 16'h30bf;
    localparam int POOL_BYTES = 32;
    localparam logic [5:0] POOL_FULL = 6'h20;
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int NUM_STAT = 6;
    localparam int ST_RX_POOL_FULL = 0;
    localparam int ST_RX_OVF = 1;
    localparam int ST_TX_POOL_READY = 2;
    localparam int ST_TX_ALL_SENT = 3;
    localparam int ST_TX_OVF = 4;
    localparam int ST_TX_UNDERRUN = 5;
    localparam logic [5:0] STAT_RESET = 6'h00;
    localparam int TX_FIFO_DEPTH = 8;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_SEND = 3'b010,
        TX_DRAIN = 3'b100
    } tx_state_t;
endpackage

// >>> logic/serial_timeslot_data_fifo_controller.sv
// Purpose: byte FIFO pools between a time-slot serial line and host/DSP
// Assumes: serial clock, data and slot strobes are asynchronous pins
`timescale 1ns/1ps

module sdc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two of at least 2");
    end

    assign o_in_ready = (cnt_ff != (AW + 1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data = mem[rp_ff];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wp_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_flush) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule

module serial_timeslot_data_fifo_controller #(
    parameter int TX_DEPTH = sdc_pkg::TX_FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_host_owns_data_controller,
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_wr,
    input wire logic i_host_rd,
    input wire logic [7:0] i_host_wdata,
    input wire logic [15:0] i_dsp_addr,
    input wire logic i_dsp_wr,
    input wire logic i_dsp_rd,
    input wire logic [7:0] i_dsp_wdata,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    input wire logic i_rx_active_set,
    input wire logic i_rx_complete_ack,
    input wire logic i_rx_reset_cmd,
    input wire logic i_tx_active_set,
    input wire logic i_tx_frame_cmd,
    input wire logic i_tx_reset_cmd,
    input wire logic [5:0] i_status_ack,
    input wire logic [5:0] i_status_mask,
    output logic [5:0] o_status,
    output logic o_attention,
    output logic o_rx_active,
    output logic o_tx_active,
    output logic o_fifo_blocked,
    input wire logic i_ser_clk,
    input wire logic i_ser_rx,
    input wire logic i_rx_slot,
    input wire logic i_tx_slot,
    output logic o_ser_tx,
    output logic o_ser_tx_oe
);
    logic [1:0] sclk_s, rxd_s, rslot_s, tslot_s;
    logic sclk_d, rslot_d, tslot_d;
    logic sclk_rise, sclk_fall, rslot_rise, tslot_rise;
    logic host_in, dsp_in, acc_wr, acc_rd;
    logic [7:0] acc_wdata;
    logic [7:0] rx_mem [0:63];
    logic [7:0] tx_mem [0:63];
    logic rx_armed_ff, rx_push_ff, rx_fill_ff, rx_sw_busy_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_sh_ff;
    logic [5:0] rx_wcnt_ff, rx_rcnt_ff;
    logic rx_handover, rx_ovf, rx_arm_now;
    logic tx_armed_ff, tx_busy_ff, tx_sw_ff, tx_pend_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_sh_ff;
    logic [5:0] tx_wcnt_ff, tx_len_ff, tx_rcnt_ff;
    sdc_pkg::tx_state_t tx_state_ff;
    logic tx_handover, tx_wr_ok, tx_ovf, tx_done, tx_arm_now;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic tx_underrun, tx_all_sent;
    logic [5:0] stat_set;

    // pins only reach logic after two flops
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            sclk_s <= 2'h0;
            rxd_s <= 2'h3;
            rslot_s <= 2'h0;
            tslot_s <= 2'h0;
            sclk_d <= 1'b0;
            rslot_d <= 1'b0;
            tslot_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], i_ser_clk};
            rxd_s <= {rxd_s[0], i_ser_rx};
            rslot_s <= {rslot_s[0], i_rx_slot};
            tslot_s <= {tslot_s[0], i_tx_slot};
            sclk_d <= sclk_s[1];
            rslot_d <= rslot_s[1];
            tslot_d <= tslot_s[1];
        end
    end

    assign sclk_rise = sclk_s[1] && !sclk_d;
    assign sclk_fall = !sclk_s[1] && sclk_d;
    assign rslot_rise = rslot_s[1] && !rslot_d;
    assign tslot_rise = tslot_s[1] && !tslot_d;

    // the idle owner's strobes are simply ignored
    assign host_in = (i_host_addr >= sdc_pkg::HOST_WIN_LO) &&
                     (i_host_addr <= sdc_pkg::HOST_WIN_HI);
    assign dsp_in = (i_dsp_addr >= sdc_pkg::DSP_WIN_LO) &&
                    (i_dsp_addr <= sdc_pkg::DSP_WIN_HI);
    assign acc_wr = i_host_owns_data_controller ? (i_host_wr && host_in)
                                                : (i_dsp_wr && dsp_in);
    assign acc_rd = i_host_owns_data_controller ? (i_host_rd && host_in)
                                                : (i_dsp_rd && dsp_in);
    assign acc_wdata = i_host_owns_data_controller ? i_host_wdata : i_dsp_wdata;

    // receive shifter; bit count restarts at every slot start
    assign rx_arm_now = rx_armed_ff || (rslot_rise && o_rx_active);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_rx_reset_cmd) begin
            o_rx_active <= 1'b0;
            rx_armed_ff <= 1'b0;
        end else begin
            if (i_rx_active_set) begin
                o_rx_active <= 1'b1;
            end
            if (!rslot_s[1]) begin
                rx_armed_ff <= 1'b0;
            end else if (rslot_rise && o_rx_active) begin
                rx_armed_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_rx_reset_cmd) begin
            rx_bit_ff <= 3'h0;
            rx_sh_ff <= 8'h00;
            rx_push_ff <= 1'b0;
        end else begin
            rx_push_ff <= 1'b0;
            if (rslot_rise) begin
                rx_bit_ff <= 3'h0;
            end
            if (sclk_rise && rslot_s[1] && rx_arm_now) begin
                rx_sh_ff <= {rx_sh_ff[6:0], rxd_s[1]};
                rx_bit_ff <= rslot_rise ? 3'h1 : rx_bit_ff + 3'h1;
                rx_push_ff <= (rx_bit_ff == sdc_pkg::LAST_BIT) && !rslot_rise;
            end
        end
    end

    // fill pool hands over at 32 bytes once software has freed its pool
    assign rx_handover = (rx_wcnt_ff == sdc_pkg::POOL_FULL) && !rx_sw_busy_ff;
    assign rx_ovf = rx_push_ff && (rx_wcnt_ff == sdc_pkg::POOL_FULL) &&
                    !rx_handover;

    always_ff @(posedge i_sys_clk) begin
        if (rx_push_ff && rx_handover) begin
            rx_mem[{!rx_fill_ff, 5'h00}] <= rx_sh_ff;
        end else if (rx_push_ff && rx_wcnt_ff != sdc_pkg::POOL_FULL) begin
            rx_mem[{rx_fill_ff, rx_wcnt_ff[4:0]}] <= rx_sh_ff;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_rx_reset_cmd) begin
            rx_fill_ff <= 1'b0;
            rx_wcnt_ff <= 6'h00;
            rx_sw_busy_ff <= 1'b0;
            rx_rcnt_ff <= 6'h00;
        end else begin
            if (rx_handover) begin
                rx_fill_ff <= !rx_fill_ff;
                rx_wcnt_ff <= {5'h00, rx_push_ff};
                rx_sw_busy_ff <= 1'b1;
                rx_rcnt_ff <= 6'h00;
            end else begin
                if (rx_push_ff && rx_wcnt_ff != sdc_pkg::POOL_FULL) begin
                    rx_wcnt_ff <= rx_wcnt_ff + 6'h01;
                end
                if (i_rx_complete_ack) begin
                    rx_sw_busy_ff <= 1'b0;
                end
                if (acc_rd && rx_sw_busy_ff && rx_rcnt_ff != sdc_pkg::POOL_FULL) begin
                    rx_rcnt_ff <= rx_rcnt_ff + 6'h01;
                end
            end
        end
    end

    // reading past the pool or with no pool owned returns zero
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= acc_rd;
            if (acc_rd && rx_sw_busy_ff && rx_rcnt_ff != sdc_pkg::POOL_FULL) begin
                o_rd_data <= rx_mem[{!rx_fill_ff, rx_rcnt_ff[4:0]}];
            end else if (acc_rd) begin
                o_rd_data <= 8'h00;
            end
        end
    end

    // transmit pools: software pool and sending pool swap on frame command
    assign o_fifo_blocked = tx_pend_ff;
    assign tx_wr_ok = acc_wr && !tx_pend_ff;
    assign tx_ovf = tx_wr_ok && (tx_wcnt_ff == sdc_pkg::POOL_FULL);
    assign tx_done = !fifo_out_valid && !tx_busy_ff;
    assign tx_handover = !i_tx_reset_cmd &&
        (((tx_state_ff == sdc_pkg::TX_IDLE) && i_tx_frame_cmd) ||
         ((tx_state_ff == sdc_pkg::TX_DRAIN) && tx_done && tx_pend_ff));
    assign tx_all_sent = (tx_state_ff == sdc_pkg::TX_DRAIN) && tx_done &&
                         !tx_pend_ff && !i_tx_reset_cmd;
    assign fifo_in_valid = (tx_state_ff == sdc_pkg::TX_SEND) &&
                           (tx_rcnt_ff != tx_len_ff);

    always_ff @(posedge i_sys_clk) begin
        if (tx_wr_ok && tx_wcnt_ff != sdc_pkg::POOL_FULL) begin
            tx_mem[{tx_sw_ff, tx_wcnt_ff[4:0]}] <= acc_wdata;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_tx_reset_cmd) begin
            tx_state_ff <= sdc_pkg::TX_IDLE;
            tx_sw_ff <= 1'b0;
            tx_wcnt_ff <= 6'h00;
            tx_len_ff <= 6'h00;
            tx_rcnt_ff <= 6'h00;
            tx_pend_ff <= 1'b0;
        end else begin
            if (tx_wr_ok && tx_wcnt_ff != sdc_pkg::POOL_FULL) begin
                tx_wcnt_ff <= tx_wcnt_ff + 6'h01;
            end
            if (fifo_in_valid && fifo_in_ready) begin
                tx_rcnt_ff <= tx_rcnt_ff + 6'h01;
            end
            if (i_tx_frame_cmd && tx_state_ff != sdc_pkg::TX_IDLE) begin
                tx_pend_ff <= 1'b1;
            end
            if (tx_handover) begin
                tx_sw_ff <= !tx_sw_ff;
                tx_len_ff <= tx_wcnt_ff;
                tx_wcnt_ff <= 6'h00;
                tx_rcnt_ff <= 6'h00;
                tx_pend_ff <= 1'b0;
            end
            unique case (tx_state_ff)
                sdc_pkg::TX_IDLE: begin
                    if (tx_handover) begin
                        tx_state_ff <= sdc_pkg::TX_SEND;
                    end
                end
                sdc_pkg::TX_SEND: begin
                    if (tx_rcnt_ff == tx_len_ff) begin
                        tx_state_ff <= sdc_pkg::TX_DRAIN;
                    end
                end
                sdc_pkg::TX_DRAIN: begin
                    if (tx_handover) begin
                        tx_state_ff <= sdc_pkg::TX_SEND;
                    end else if (tx_done) begin
                        tx_state_ff <= sdc_pkg::TX_IDLE;
                    end
                end
                default: begin
                    tx_state_ff <= sdc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    // small fifo decouples the pool read from the serial bit rate
    sdc_fifo #(
        .WIDTH(8),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_flush(i_tx_reset_cmd),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(tx_mem[{!tx_sw_ff, tx_rcnt_ff[4:0]}]),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    // bits change on the falling serial edge, bytes load at bit zero
    assign tx_arm_now = tx_armed_ff || (tslot_rise && o_tx_active);
    assign fifo_out_ready = sclk_fall && tslot_s[1] && tx_arm_now &&
                            ((tx_bit_ff == 3'h0) || tslot_rise);
    // a pool still queued behind the shifter counts as transmission in progress
    assign tx_underrun = fifo_out_ready && !fifo_out_valid &&
                         ((tx_state_ff == sdc_pkg::TX_SEND) || tx_pend_ff);

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_tx_reset_cmd) begin
            tx_armed_ff <= 1'b0;
        end else if (!tslot_s[1]) begin
            tx_armed_ff <= 1'b0;
        end else if (tslot_rise && o_tx_active) begin
            tx_armed_ff <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_tx_active <= 1'b0;
        end else if (i_tx_active_set) begin
            o_tx_active <= 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst || i_tx_reset_cmd) begin
            tx_bit_ff <= 3'h0;
            tx_sh_ff <= 8'hff;
            tx_busy_ff <= 1'b0;
            o_ser_tx <= 1'b1;
            o_ser_tx_oe <= 1'b0;
        end else begin
            o_ser_tx_oe <= tslot_s[1];
            if (!tslot_s[1]) begin
                o_ser_tx <= 1'b1;
                tx_bit_ff <= 3'h0;
            end else if (fifo_out_ready) begin
                tx_bit_ff <= 3'h1;
                if (fifo_out_valid) begin
                    o_ser_tx <= fifo_out_data[7];
                    tx_sh_ff <= {fifo_out_data[6:0], 1'b1};
                    tx_busy_ff <= 1'b1;
                end else begin
                    o_ser_tx <= 1'b1;
                    tx_sh_ff <= 8'hff;
                    tx_busy_ff <= 1'b0;
                end
            end else if (sclk_fall && tx_arm_now) begin
                o_ser_tx <= tx_sh_ff[7];
                tx_sh_ff <= {tx_sh_ff[6:0], 1'b1};
                tx_bit_ff <= tx_bit_ff + 3'h1;
            end else if (!tx_arm_now) begin
                o_ser_tx <= 1'b1;
            end
        end
    end

    // set wins over a same-cycle acknowledge
    assign stat_set[sdc_pkg::ST_RX_POOL_FULL] = rx_handover;
    assign stat_set[sdc_pkg::ST_RX_OVF] = rx_ovf;
    assign stat_set[sdc_pkg::ST_TX_POOL_READY] = tx_handover || i_tx_reset_cmd;
    assign stat_set[sdc_pkg::ST_TX_ALL_SENT] = tx_all_sent;
    assign stat_set[sdc_pkg::ST_TX_OVF] = tx_ovf;
    assign stat_set[sdc_pkg::ST_TX_UNDERRUN] = tx_underrun;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_status <= sdc_pkg::STAT_RESET;
            o_attention <= 1'b0;
        end else begin
            o_status <= (o_status & ~i_status_ack) | stat_set;
            o_attention <= |(o_status & ~i_status_mask);
        end
    end

    owner_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (!i_host_owns_data_controller && !i_dsp_rd) |=> !o_rd_valid)
        else $error("read taken from a bus that does not own the window");
    window_hole_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_host_owns_data_controller && i_host_addr == 8'h7f) |-> !acc_wr && !acc_rd)
        else $error("address below window decoded");
    rx_full_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (rx_handover && !i_rx_reset_cmd) |=> o_status[sdc_pkg::ST_RX_POOL_FULL] && rx_sw_busy_ff)
        else $error("pool full not flagged after 32 bytes");
    rx_drop_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (rx_push_ff && rx_sw_busy_ff && rx_wcnt_ff == 6'h20 && !i_rx_reset_cmd)
        |=> o_status[sdc_pkg::ST_RX_OVF])
        else $error("dropped byte not flagged");
    rx_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_rx_reset_cmd |=> !o_rx_active && rx_wcnt_ff == 6'h00 && !rx_sw_busy_ff)
        else $error("receiver reset incomplete");
    tx_hiz_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !tslot_s[1] |=> !o_ser_tx_oe)
        else $error("driving outside transmit slot");
    tx_idle_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_ser_tx_oe && !tx_busy_ff && !fifo_out_valid && !$past(tx_busy_ff)) |-> o_ser_tx)
        else $error("no idle ones with empty fifo");
    all_sent_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(o_status[sdc_pkg::ST_TX_ALL_SENT]) |-> $past(tx_done))
        else $error("all sent raised with data pending");
    tx_ovf_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (tx_wr_ok && tx_wcnt_ff == 6'h20 && !i_tx_reset_cmd) |=>
        o_status[sdc_pkg::ST_TX_OVF] && tx_wcnt_ff == 6'h20)
        else $error("33rd byte accepted or not flagged");
    tx_block_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_fifo_blocked && !tx_handover && !i_tx_reset_cmd) |=> $stable(tx_wcnt_ff))
        else $error("write accepted while blocked");
    tx_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_tx_reset_cmd |=> o_status[sdc_pkg::ST_TX_POOL_READY] && !fifo_out_valid)
        else $error("transmitter reset incomplete");
    status_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (o_status[sdc_pkg::ST_TX_UNDERRUN] && !i_status_ack[sdc_pkg::ST_TX_UNDERRUN])
        |=> o_status[sdc_pkg::ST_TX_UNDERRUN])
        else $error("status dropped without acknowledge");
endmodule

// >>> dv/sdc_link_model.sv
// Purpose: far-side time-slot link, drives slot strobes, serial clock and rx data
// Assumes: serial clock stands still low outside slots, 80 ns period inside
// Notes: released rx line shows the inverse of its last bit
`timescale 1ns/1ps

module sdc_link_model (
    output logic o_ser_clk,
    output logic o_ser_rx,
    output logic o_rx_slot,
    output logic o_tx_slot,
    input wire logic i_ser_tx,
    input wire logic i_ser_tx_oe
);
    logic [15:0] cap;
    initial begin
        o_ser_clk = 1'b0;
        o_ser_rx = 1'b0;
        o_rx_slot = 1'b0;
        o_tx_slot = 1'b0;
        cap = 16'h0000;
    end
    // tx slots get one extra period so the last falling-edge bit is sampled
    task automatic slot(input int nbytes, input logic [7:0] base, input logic rx,
                        input logic tx);
        int i;
        logic [7:0] b;
        o_rx_slot = rx;
        o_tx_slot = tx;
        for (i = 0; i < nbytes * 8 + int'(tx); i++) begin
            b = base + 8'(i / 8);
            o_ser_rx = rx ? b[7 - i % 8] : ~o_ser_rx;
            #40;
            o_ser_clk = 1'b1;
            if (i > 0) cap = {cap[14:0], i_ser_tx};
            #40;
            o_ser_clk = 1'b0;
        end
        o_rx_slot = 1'b0;
        o_tx_slot = 1'b0;
        o_ser_rx = ~o_ser_rx;
    endtask
endmodule

// >>> dv/serial_timeslot_data_fifo_controller_bench.sv
// Purpose: directed bench for the serial time-slot data controller
// Assumes: host owns the window except during the owner swap, masks open except for one attention check
// Notes: two receive pools with a dropped byte, owner swap, queued transmit frames
`timescale 1ns/1ps

module serial_timeslot_data_fifo_controller_bench;
    logic clk = 1'b0, rst = 1'b1, own = 1'b1, hwr = 1'b0, hrd = 1'b0, dwr = 1'b0, drd = 1'b0;
    logic [7:0] haddr = 8'h80, hwd = 8'h00, rdd;
    logic [15:0] daddr = 16'h3080;
    logic ras = 1'b0, rack = 1'b0, rx_reset_cmd = 1'b0, tas = 1'b0, tfc = 1'b0, tres = 1'b0;
    logic [5:0] sack = 6'h00, smask = 6'h00, st;
    logic rdv, att, rxa, txa, blk, sclk, srx, rsl, tsl, stx, soe;
    int fail_count = 0, n_compared = 0, i;
    always #2 clk = ~clk;
    serial_timeslot_data_fifo_controller u_serial_timeslot_data_fifo_controller (
        .i_sys_clk(clk), .i_rst(rst), .i_host_owns_data_controller(own),
        .i_host_addr(haddr), .i_host_wr(hwr), .i_host_rd(hrd), .i_host_wdata(hwd),
        .i_dsp_addr(daddr), .i_dsp_wr(dwr), .i_dsp_rd(drd), .i_dsp_wdata(8'h00),
        .o_rd_data(rdd), .o_rd_valid(rdv), .i_rx_active_set(ras), .i_rx_complete_ack(rack),
        .i_rx_reset_cmd(rx_reset_cmd), .i_tx_active_set(tas), .i_tx_frame_cmd(tfc),
        .i_tx_reset_cmd(tres), .i_status_ack(sack), .i_status_mask(smask), .o_status(st),
        .o_attention(att), .o_rx_active(rxa), .o_tx_active(txa), .o_fifo_blocked(blk),
        .i_ser_clk(sclk), .i_ser_rx(srx), .i_rx_slot(rsl), .i_tx_slot(tsl),
        .o_ser_tx(stx), .o_ser_tx_oe(soe));
    sdc_link_model u_sdc_link_model (.o_ser_clk(sclk), .o_ser_rx(srx), .o_rx_slot(rsl),
        .o_tx_slot(tsl), .i_ser_tx(stx), .i_ser_tx_oe(soe));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one-cycle command pulse: 0 rx active, 1 rx ack, 2 rx reset, 3 tx active, 4 frame, 5 tx reset
    task automatic pulse(input int w);
        @(posedge clk) {tres, tfc, tas, rx_reset_cmd, rack, ras} <= 6'(1 << w);
        @(posedge clk) {tres, tfc, tas, rx_reset_cmd, rack, ras} <= 6'h00;
    endtask
    task automatic rd(input logic host, input logic [15:0] a);
        @(posedge clk) begin hrd <= host; drd <= !host; haddr <= a[7:0]; daddr <= a; end
        @(posedge clk) begin hrd <= 1'b0; drd <= 1'b0; end
        #1;
    endtask
    task automatic hwrite(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin hwr <= 1'b1; haddr <= a; hwd <= d; end
        @(posedge clk) hwr <= 1'b0;
    endtask
    task automatic ack(input logic [5:0] m);
        @(posedge clk) sack <= m;
        @(posedge clk) sack <= 6'h00;
        #1;
    endtask
    // status bit wait, bounded, then compared
    task automatic wait_st(input int b);
        int n;
        for (n = 0; n < 200 && st[b] !== 1'b1; n++) @(posedge clk);
        #1;
        chk(16'(st[b]), 16'h0001);
    endtask
    initial begin
        #100000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({st, soe, stx}, 16'h0001);
        pulse(0);
        #1;
        chk(16'(rxa), 16'h0001);
        u_sdc_link_model.slot(32, 8'h40, 1'b1, 1'b0);
        wait_st(sdc_pkg::ST_RX_POOL_FULL);
        chk(16'(att), 16'h0001);
        @(posedge clk) smask <= 6'h3f;
        repeat (2) @(posedge clk);
        #1;
        chk(16'(att), 16'h0000);
        @(posedge clk) smask <= 6'h00;
        rd(1'b0, 16'h3080);
        chk(16'(rdv), 16'h0000);
        for (i = 0; i < 32; i++) begin
            rd(1'b1, i[0] ? 16'h00bf : 16'h0080);
            chk({7'h00, rdv, rdd}, {8'h01, 8'h40 + 8'(i)});
        end
        // second pool fills while software still holds the first: 33rd byte drops
        u_sdc_link_model.slot(33, 8'h60, 1'b1, 1'b0);
        chk(16'(st[sdc_pkg::ST_RX_OVF]), 16'h0001);
        pulse(1);
        ack(6'h01);
        chk(16'(st[0]), 16'h0000);
        rd(1'b1, 16'h0080);
        chk({7'h00, rdv, rdd}, 16'h0160);
        @(posedge clk) own <= 1'b0;
        rd(1'b0, 16'h30bf);
        chk({7'h00, rdv, rdd}, 16'h0161);
        rd(1'b1, 16'h0080);
        chk(16'(rdv), 16'h0000);
        @(posedge clk) own <= 1'b1;
        hwrite(8'h80, 8'ha5);
        pulse(4);
        wait_st(sdc_pkg::ST_TX_POOL_READY);
        ack(6'h3f);
        pulse(3);
        #1;
        chk(16'(soe), 16'h0000);
        chk(16'(txa), 16'h0001);
        u_sdc_link_model.slot(2, 8'h00, 1'b0, 1'b1);
        chk(u_sdc_link_model.cap, 16'ha5ff);
        chk(16'(u_sdc_link_model.cap[7:0]), 16'h00ff);
        wait_st(sdc_pkg::ST_TX_ALL_SENT);
        for (i = 0; i < 33; i++) hwrite(8'h80, 8'(i));
        wait_st(sdc_pkg::ST_TX_OVF);
        ack(6'h3f);
        pulse(5);
        wait_st(sdc_pkg::ST_TX_POOL_READY);
        ack(6'h3f);
        // second frame command while the first still queues: writes blocked until it drains
        hwrite(8'h80, 8'h3c);
        pulse(4);
        hwrite(8'h80, 8'hc3);
        pulse(4);
        #1;
        chk(16'(blk), 16'h0001);
        hwrite(8'h80, 8'h00);
        u_sdc_link_model.slot(3, 8'h00, 1'b0, 1'b1);
        chk(u_sdc_link_model.cap, 16'hffc3);
        chk(16'(blk), 16'h0000);
        chk(16'(st[sdc_pkg::ST_TX_UNDERRUN]), 16'h0001);
        pulse(2);
        #1;
        chk(16'(rxa), 16'h0000);
        rd(1'b1, 16'h0080);
        chk({7'h00, rdv, rdd}, 16'h0100);
        close_out();
    end
endmodule
